// ---- design/mre_consts.vh ----
// constants and operation codes for the move/or/return/rotate executor
// How it works
// - subroutine return pops PC, takes two cycles
// - literal return pops PC, loads immediate
// - interrupt return pops PC, sets interrupt enable
// - interrupt enable gates every interrupt source
// - in-place rotate left, bit 7 to 0
// - accumulator rotate left result goes to accumulator
// - accumulator rotate leaves memory byte unchanged
`ifndef MRE_CONSTS_VH
`define MRE_CONSTS_VH
`define MRE_OP_NOP 4'h0
`define MRE_OP_MOV_A_M 4'h1
`define MRE_OP_MOV_A_X 4'h2
`define MRE_OP_MOV_M_A 4'h3
`define MRE_OP_OR_A_M 4'h4
`define MRE_OP_OR_A_X 4'h5
`define MRE_OP_OR_M 4'h6
`define MRE_OP_RET 4'h7
`define MRE_OP_RET_X 4'h8
`define MRE_OP_INTERRUPT_RETURN 4'h9
`define MRE_OP_RL 4'ha
`define MRE_OP_RLA 4'hb
`define MRE_ACC_RST 8'h00
`define MRE_GIE_RST 1'b0
`define MRE_RET_CYCLES 2'h2
`endif

// ---- design/mre_alu.v ----
// combinational result unit: or, rotate and zero test
`timescale 1ns/1ps
module mre_alu #(
	parameter W = 8
) (
	input wire [3:0] op_i,
	input wire [W-1:0] acc_i,
	input wire [W-1:0] mem_i,
	input wire [W-1:0] imm_i,
	output reg [W-1:0] res_o,
	output wire zero_o
);
`include "mre_consts.vh"
	always @* begin
		case (op_i)
			`MRE_OP_OR_A_M, `MRE_OP_OR_M: res_o = acc_i | mem_i;
			`MRE_OP_OR_A_X: res_o = acc_i | imm_i;
			`MRE_OP_RL, `MRE_OP_RLA: res_o = {mem_i[W-2:0], mem_i[W-1]};
			`MRE_OP_MOV_A_M: res_o = mem_i;
			`MRE_OP_MOV_A_X, `MRE_OP_RET_X: res_o = imm_i;
			`MRE_OP_MOV_M_A: res_o = acc_i;
			default: res_o = acc_i;
		endcase
	end
	assign zero_o = (res_o == {W{1'b0}});
endmodule

// ---- design/mre_exec.v ----
// executor for moves, or, nop, returns and left rotates
`timescale 1ns/1ps
module mre_exec #(
	parameter W = 8,
	parameter PCW = 12
) (
	input wire MCLK_I,
	input wire RST_I,
	input wire START_I,
	input wire [3:0] OP_I,
	input wire [W-1:0] IMM_I,
	input wire [W-1:0] MEM_RDATA_I,
	input wire [PCW-1:0] STACK_TOP_I,
	input wire [PCW-1:0] PC_I,
	input wire IRQ_REQ_I,
	input wire GIE_CLR_I,
	output reg [W-1:0] ACC_O,
	output reg [W-1:0] MEM_WDATA_O,
	output reg MEM_WE_O,
	output reg [PCW-1:0] PC_O,
	output reg PC_LOAD_O,
	output reg STACK_POP_O,
	output reg ZERO_O,
	output reg GIE_O,
	output reg IRQ_O,
	output reg BUSY_O,
	output reg DONE_O
);
`include "mre_consts.vh"
	// ----------------------------------------
	// local state
	// ----------------------------------------
	localparam ST_IDLE = 1'b0;
	localparam ST_RET = 1'b1;
	reg state_r;
	reg state_nxt;
	reg [1:0] ret_cnt_r;
	reg [1:0] ret_cnt_nxt;
	reg [W-1:0] acc_nxt;
	reg [W-1:0] mem_wdata_nxt;
	reg mem_we_nxt;
	reg [PCW-1:0] pc_nxt;
	reg pc_load_nxt;
	reg stack_pop_nxt;
	reg zero_nxt;
	reg gie_nxt;
	reg irq_nxt;
	reg busy_nxt;
	reg done_nxt;
	wire [W-1:0] res;
	wire zero;
	wire take;
	wire ret_take;
	wire interrupt_return_take;
	wire ret_last;
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function is_ret;
		input [3:0] op;
		begin
			is_ret = (op == `MRE_OP_RET) || (op == `MRE_OP_RET_X) || (op == `MRE_OP_INTERRUPT_RETURN);
		end
	endfunction
	function writes_mem;
		input [3:0] op;
		begin
			writes_mem = (op == `MRE_OP_MOV_M_A) || (op == `MRE_OP_OR_M) || (op == `MRE_OP_RL);
		end
	endfunction
	// ----------------------------------------
	// result unit and strobes
	// ----------------------------------------
	mre_alu #(.W(W)) u_alu (
		.op_i(OP_I),
		.acc_i(ACC_O),
		.mem_i(MEM_RDATA_I),
		.imm_i(IMM_I),
		.res_o(res),
		.zero_o(zero)
	);
	// start is ignored during a return
	assign take = START_I && (state_r == ST_IDLE);
	assign ret_take = take && is_ret(OP_I);
	assign interrupt_return_take = take && (OP_I == `MRE_OP_INTERRUPT_RETURN);
	assign ret_last = (state_r == ST_RET) && (ret_cnt_r <= 2'h1);
	// ----------------------------------------
	// return sequencer
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		ret_cnt_nxt = ret_cnt_r;
		busy_nxt = BUSY_O;
		stack_pop_nxt = 1'b0;
		done_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (ret_take) begin
					stack_pop_nxt = 1'b1;
					busy_nxt = 1'b1;
					ret_cnt_nxt = `MRE_RET_CYCLES - 2'h1;
					state_nxt = ST_RET;
				end else if (take) begin
					done_nxt = 1'b1;
				end
			end
			ST_RET: begin
				if (ret_last) begin
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end else begin
					ret_cnt_nxt = ret_cnt_r - 2'h1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				busy_nxt = 1'b0;
			end
		endcase
	end
	// ----------------------------------------
	// interrupt enable
	// ----------------------------------------
	always @* begin
		gie_nxt = GIE_O;
		if (GIE_CLR_I) begin
			gie_nxt = 1'b0;
		end
		// interrupt_return set wins over a clear
		if (interrupt_return_take) begin
			gie_nxt = 1'b1;
		end
		irq_nxt = IRQ_REQ_I & GIE_O;
	end
	// ----------------------------------------
	// accumulator, memory, pc and zero flag
	// ----------------------------------------
	always @* begin
		acc_nxt = ACC_O;
		mem_wdata_nxt = MEM_WDATA_O;
		mem_we_nxt = 1'b0;
		pc_nxt = PC_O;
		pc_load_nxt = 1'b0;
		zero_nxt = ZERO_O;
		if (ret_take) begin
			pc_nxt = STACK_TOP_I;
			pc_load_nxt = 1'b1;
			if (OP_I == `MRE_OP_RET_X) begin
				acc_nxt = res;
			end
		end else if (take) begin
			pc_nxt = PC_I + {{(PCW-1){1'b0}}, 1'b1};
			pc_load_nxt = 1'b1;
			if (writes_mem(OP_I)) begin
				mem_wdata_nxt = res;
				mem_we_nxt = 1'b1;
			end
			case (OP_I)
				`MRE_OP_MOV_A_M, `MRE_OP_MOV_A_X: begin
					acc_nxt = res;
				end
				`MRE_OP_RLA: begin
					acc_nxt = res;
				end
				`MRE_OP_OR_A_M, `MRE_OP_OR_A_X: begin
					acc_nxt = res;
					zero_nxt = zero;
				end
				`MRE_OP_OR_M: begin
					zero_nxt = zero;
				end
				default: begin
				end
			endcase
		end
	end
	// ----------------------------------------
	// sequencer registers
	// ----------------------------------------
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= ST_IDLE;
			ret_cnt_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			ret_cnt_r <= ret_cnt_nxt;
		end
	end
	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			ACC_O <= `MRE_ACC_RST;
			MEM_WDATA_O <= {W{1'b0}};
			MEM_WE_O <= 1'b0;
			PC_O <= {PCW{1'b0}};
			PC_LOAD_O <= 1'b0;
			STACK_POP_O <= 1'b0;
			ZERO_O <= 1'b0;
			GIE_O <= `MRE_GIE_RST;
			IRQ_O <= 1'b0;
			BUSY_O <= 1'b0;
			DONE_O <= 1'b0;
		end else begin
			ACC_O <= acc_nxt;
			MEM_WDATA_O <= mem_wdata_nxt;
			MEM_WE_O <= mem_we_nxt;
			PC_O <= pc_nxt;
			PC_LOAD_O <= pc_load_nxt;
			STACK_POP_O <= stack_pop_nxt;
			ZERO_O <= zero_nxt;
			GIE_O <= gie_nxt;
			IRQ_O <= irq_nxt;
			BUSY_O <= busy_nxt;
			DONE_O <= done_nxt;
		end
	end
endmodule

// ---- tb/mre_exec_monitor.sv ----
// port checker for the executor
`timescale 1ns/1ps
`include "mre_consts.vh"
module mre_exec_monitor #(
	parameter W = 8,
	parameter PCW = 12
) (
	input wire MCLK_I,
	input wire RST_I,
	input wire START_I,
	input wire IRQ_REQ_I,
	input wire [3:0] OP_I,
	input wire [W-1:0] IMM_I,
	input wire [W-1:0] MEM_RDATA_I,
	input wire [PCW-1:0] STACK_TOP_I,
	input wire [W-1:0] ACC_O,
	input wire [W-1:0] MEM_WDATA_O,
	input wire MEM_WE_O,
	input wire [PCW-1:0] PC_O,
	input wire PC_LOAD_O,
	input wire STACK_POP_O,
	input wire ZERO_O,
	input wire GIE_O,
	input wire IRQ_O,
	input wire BUSY_O,
	input wire DONE_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	wire go = START_I && !BUSY_O;
	wire [W-1:0] rl = {MEM_RDATA_I[W-2:0], MEM_RDATA_I[W-1]};
	// ----------
	// properties
	// ----------
	property p_ret;
		go && OP_I == `MRE_OP_RET |=> PC_LOAD_O && STACK_POP_O && BUSY_O &&
			PC_O == $past(STACK_TOP_I) ##1 DONE_O && !BUSY_O;
	endproperty
	a_ret: assert property (p_ret) else $error("ret");
	property p_retx;
		go && OP_I == `MRE_OP_RET_X |=> STACK_POP_O && ACC_O == $past(IMM_I);
	endproperty
	a_retx: assert property (p_retx) else $error("retx");
	property p_interrupt_return;
		go && OP_I == `MRE_OP_INTERRUPT_RETURN |=> STACK_POP_O && GIE_O;
	endproperty
	a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt_return");
	property p_irq;
		IRQ_O == $past(IRQ_REQ_I && GIE_O);
	endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_rl;
		go && OP_I == `MRE_OP_RL |=> MEM_WE_O && MEM_WDATA_O == $past(rl);
	endproperty
	a_rl: assert property (p_rl) else $error("rl");
	property p_rla;
		go && OP_I == `MRE_OP_RLA |=> ACC_O == $past(rl);
	endproperty
	a_rla: assert property (p_rla) else $error("rla");
	property p_rlam;
		go && OP_I == `MRE_OP_RLA |=> !MEM_WE_O;
	endproperty
	a_rlam: assert property (p_rlam) else $error("rla we");
	property p_or;
		go && OP_I == `MRE_OP_OR_A_X |=> ZERO_O == ($past(ACC_O | IMM_I) == {W{1'b0}});
	endproperty
	a_or: assert property (p_or) else $error("or");
	property p_busy;
		START_I && BUSY_O |=> !PC_LOAD_O && !STACK_POP_O && !MEM_WE_O;
	endproperty
	a_busy: assert property (p_busy) else $error("start taken while busy");
	property p_movz;
		go && (OP_I == `MRE_OP_MOV_A_M || OP_I == `MRE_OP_MOV_M_A)
			|=> ZERO_O == $past(ZERO_O);
	endproperty
	a_movz: assert property (p_movz) else $error("move changed zero");
	c_ret: cover property (go && OP_I == `MRE_OP_RET);
	c_rl: cover property (go && OP_I == `MRE_OP_RL);
	c_irq: cover property (IRQ_O);
endmodule
bind mre_exec mre_exec_monitor #(.W(W), .PCW(PCW)) i_mon(.*);

// ---- tb/mre_exec_test.sv ----
// self-checking bench for the executor
`timescale 1ns/1ps
`include "mre_consts.vh"
`define CHK(n,e,s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
	$display("FAIL %s exp %h got %h", n, e, s); end end
module mre_exec_test;
	logic c = 0, r = 1, st = 0, irq = 0, clr = 0;
	logic [3:0] op = 0;
	logic [7:0] x = 0, m = 0;
	logic [11:0] top = 12'h0a5, pci = 12'h010;
	wire [7:0] acc, wd;
	wire [11:0] pco;
	wire we, pl, pop, z, gie, iro, bsy, dn;
	int mismatches = 0, n_tests = 0, cyc = 0;
	always #10 c = ~c;
	mre_exec i_dut(.MCLK_I(c), .RST_I(r), .START_I(st), .OP_I(op), .IMM_I(x), .MEM_RDATA_I(m),
		.STACK_TOP_I(top), .PC_I(pci), .IRQ_REQ_I(irq), .GIE_CLR_I(clr), .ACC_O(acc),
		.MEM_WDATA_O(wd), .MEM_WE_O(we), .PC_O(pco), .PC_LOAD_O(pl), .STACK_POP_O(pop),
		.ZERO_O(z), .GIE_O(gie), .IRQ_O(iro), .BUSY_O(bsy), .DONE_O(dn));
	task run(input [3:0] o, input [7:0] xi, mi);
		@(negedge c);
		op = o;
		x = xi;
		m = mi;
		st = 1;
		@(negedge c);
		st = 0;
	endtask
	task t_ret;
		run(`MRE_OP_RET, 0, 0);
		`CHK("ret", 15'h70a5, {pl, pop, bsy, pco})
		@(negedge c);
		`CHK("done", 2'h2, {dn, bsy})
		run(`MRE_OP_RET_X, 8'h5a, 0);
		`CHK("acc", 8'h5a, acc)
		@(negedge c);
	endtask
	task t_interrupt_return;
		irq = 1;
		run(`MRE_OP_INTERRUPT_RETURN, 0, 0);
		`CHK("interrupt_return", 3'h6, {gie, pop, iro})
		@(negedge c);
		`CHK("irq", 1'b1, iro)
		clr = 1;
		@(negedge c);
		clr = 0;
		@(negedge c);
		`CHK("irq", 2'h0, {gie, iro})
		clr = 1;
		run(`MRE_OP_INTERRUPT_RETURN, 0, 0);
		clr = 0;
		`CHK("interrupt_return over clear", 1'b1, gie)
		@(negedge c);
	endtask
	task t_rot;
		run(`MRE_OP_RL, 0, 8'h81);
		`CHK("rl", 9'h103, {we, wd})
		run(`MRE_OP_RLA, 0, 8'h40);
		`CHK("rla", 9'h080, {we, acc})
	endtask
	task t_or;
		run(`MRE_OP_MOV_A_X, 8'h00, 0);
		run(`MRE_OP_OR_A_X, 8'h00, 0);
		`CHK("z", 1'b1, z)
		run(`MRE_OP_OR_A_M, 0, 8'h30);
		`CHK("or", 9'h030, {z, acc})
		pci = 12'h7ff;
		run(`MRE_OP_NOP, 0, 0);
		`CHK("nop", 14'h2800, {pl, z, pco})
	endtask
	task t_mov;
		run(`MRE_OP_MOV_A_X, 8'h00, 0);
		run(`MRE_OP_OR_A_M, 0, 8'h00);
		run(`MRE_OP_MOV_A_M, 0, 8'hc3);
		`CHK("mov a,m", 10'h3c3, {dn, z, acc})
		run(`MRE_OP_MOV_M_A, 0, 0);
		`CHK("mov m,a", 10'h3c3, {we, z, wd})
		run(`MRE_OP_OR_M, 0, 8'h0c);
		`CHK("or m", 18'h2cfc3, {we, z, wd, acc})
		top = 12'h3c1;
		run(`MRE_OP_RET, 0, 0);
		`CHK("ret top", 14'h33c1, {pop, bsy, pco})
		op = `MRE_OP_MOV_A_X;
		x = 8'hff;
		st = 1;
		@(negedge c);
		st = 0;
		`CHK("busy", 11'h4c3, {dn, bsy, pl, acc})
	endtask
	task t_reset;
		@(negedge c);
		r = 1;
		@(negedge c);
		`CHK("reset", 25'h0, {acc, z, gie, iro, bsy, dn, pco})
		repeat (2) @(negedge c);
		r = 0;
		run(`MRE_OP_RL, 0, 8'h01);
		`CHK("rl after reset", 9'h102, {we, wd})
	endtask
	task tally_and_finish;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge c) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (10) @(negedge c);
		r = 0;
		t_ret;
		t_interrupt_return;
		t_rot;
		t_or;
		t_mov;
		t_reset;
		tally_and_finish;
	end
endmodule
